// file: core/qec_cfg.svh
// register map, field positions and reset values of the quadrature event counter
`ifndef QEC_CFG_SVH
`define QEC_CFG_SVH

// ==========================================================
// register byte offsets
`define QEC_OFS_RUN 5'h00
`define QEC_OFS_MODE 5'h04
`define QEC_OFS_CNT2 5'h10
`define QEC_OFS_CNT3 5'h14
`define QEC_OFS_CNT4 5'h18

// ==========================================================
// field positions of the mode register
`define QEC_MODE_FREE_LSB 0
`define QEC_MODE_X4SEL_BIT 3
`define QEC_MODE_IDXEN_BIT 4
`define QEC_MODE_IDXPOL_BIT 5

// ==========================================================
// widths, reset values and count limits
`define QEC_NUM_CH 3
`define QEC_CNT_W 16
`define QEC_RUN_RST 3'h0
`define QEC_MODE_RST 6'h00
`define QEC_CNT_RST 16'h0000
`define QEC_CNT_MAX 16'hFFFF
`define QEC_CNT_MIN 16'h0000

`endif

// file: core/qec_pkg.sv
// types shared by the quadrature event counter
package qec_pkg;
	typedef logic [31:0] qec_word_t;
	typedef logic [4:0] qec_addr_t;
	typedef logic [15:0] qec_count_t;
	typedef enum logic {QEC_DOWN, QEC_UP} qec_dir_e;
endpackage

// file: core/qec_top.sv
// quadrature event counter for channels 2 to 4 with an Avalon-MM register slave
// Operation
// - count source is each channel's phase pair only
// - direction comes from phase relation, not software
// - reload on wrap, or free-run without reload
// - period FFFFh-n+1 up, n+1 down
// - writing run bit 1 starts counting
// - writing run bit 0 halts counting
// - overflow or underflow raises interrupt request
// - reading count register returns current count
// - write before first edge loads reload and counter
// - write while counting loads reload only
// - normal on channels 2,3; x4 on 3,4
// - normal: A high, B rise up, fall down
// - x4: B rises with A high, count up
// - x4: B falls with A high, count down
// - channel 3 index pulse clears count to zero
// - channel 3 selectable; 2 normal, 4 x4 fixed
// - index clear needs zero write, enable, free x4
// - index clear happens at next count timing
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "qec_cfg.svh"

module qec_top (
	input wire logic clk_sys, // 10 MHz system clock
	input wire logic rst_n, // synchronous reset, low active
	input wire qec_pkg::qec_addr_t avsAddress, // byte address
	input wire logic avsRead, // read request
	input wire logic avsWrite, // write request
	input wire qec_pkg::qec_word_t avsWritedata, // write data
	output qec_pkg::qec_word_t avsReaddata, // read data
	output logic avsWaitrequest, // high until the answer
	input wire logic [2:0] phaseAIn, // phase a pins, channels 2..4
	input wire logic [2:0] phaseBIn, // phase b pins, channels 2..4
	input wire logic indexPulseIn, // index pulse pin, channel 3
	output logic [2:0] irqReq // one-cycle request per channel
);
	import qec_pkg::*;

	// ==========================================================
	// input synchronisers and edge history
	logic [6:0] pinRaw;
	logic [6:0] sync1Reg;
	logic [6:0] sync2Reg;
	logic [6:0] prevReg;
	assign pinRaw = {indexPulseIn, phaseAIn, phaseBIn};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sync1Reg <= 7'h00;
			sync2Reg <= 7'h00;
			prevReg <= 7'h00;
		end else begin
			sync1Reg <= pinRaw;
			sync2Reg <= sync1Reg;
			prevReg <= sync2Reg;
		end
	end

	// ==========================================================
	// bus slave
	logic waitReg;
	logic accept;
	logic wrHit;
	logic [2:0] runReg;
	logic [5:0] modeReg;
	qec_count_t cntReg [3];
	qec_count_t reloadReg [3];
	logic [2:0] cntWrSel;
	qec_word_t rdMux;

	assign accept = (avsRead | avsWrite) & waitReg;
	assign wrHit = avsWrite & ~waitReg;
	assign cntWrSel[0] = wrHit & (avsAddress == `QEC_OFS_CNT2);
	assign cntWrSel[1] = wrHit & (avsAddress == `QEC_OFS_CNT3);
	assign cntWrSel[2] = wrHit & (avsAddress == `QEC_OFS_CNT4);
	assign avsWaitrequest = waitReg;

	always_comb begin
		rdMux = 32'h00000000;
		unique case (avsAddress)
			`QEC_OFS_RUN: rdMux = {29'h00000000, runReg};
			`QEC_OFS_MODE: rdMux = {26'h0000000, modeReg};
			`QEC_OFS_CNT2: rdMux = {16'h0000, cntReg[0]};
			`QEC_OFS_CNT3: rdMux = {16'h0000, cntReg[1]};
			`QEC_OFS_CNT4: rdMux = {16'h0000, cntReg[2]};
			default: rdMux = 32'h00000000;
		endcase
	end

	// answer one cycle after the request is seen
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			waitReg <= 1'b1;
			avsReaddata <= 32'h00000000;
		end else begin
			waitReg <= ~accept;
			if (accept && avsRead) begin
				avsReaddata <= rdMux;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			runReg <= `QEC_RUN_RST;
		end else if (wrHit && avsAddress == `QEC_OFS_RUN) begin
			runReg <= avsWritedata[2:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			modeReg <= `QEC_MODE_RST;
		end else if (wrHit && avsAddress == `QEC_OFS_MODE) begin
			modeReg <= avsWritedata[5:0];
		end
	end

	// ==========================================================
	// index pulse handling, channel 3 only
	logic idxEdge;
	logic idxArmedReg;
	logic idxPendReg;
	logic idxActive;
	logic [2:0] countEv;

	assign idxEdge = modeReg[`QEC_MODE_IDXPOL_BIT] ? (sync2Reg[6] & ~prevReg[6])
		: (~sync2Reg[6] & prevReg[6]);
	assign idxActive = idxArmedReg & modeReg[`QEC_MODE_IDXEN_BIT]
		& modeReg[`QEC_MODE_X4SEL_BIT] & modeReg[`QEC_MODE_FREE_LSB + 1];

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			idxArmedReg <= 1'b0;
		end else if (!modeReg[`QEC_MODE_IDXEN_BIT]) begin
			idxArmedReg <= 1'b0;
		end else if (cntWrSel[1]) begin
			idxArmedReg <= (avsWritedata[15:0] == `QEC_CNT_MIN);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			idxPendReg <= 1'b0;
		end else begin
			idxPendReg <= (idxActive & idxEdge) | (idxPendReg & ~countEv[1] & idxActive);
		end
	end

	// ==========================================================
	// checks of bus slave, synchroniser and index logic
	AST_WAIT_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!avsWaitrequest |=> avsWaitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_WAIT_ANSWER: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avsWaitrequest && (avsRead || avsWrite)) |=> !avsWaitrequest)
		else $error("request not answered after one cycle");
	AST_RD_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(accept && avsRead && avsAddress == `QEC_OFS_CNT3)
		|=> avsReaddata == {16'h0000, $past(cntReg[1])})
		else $error("count readback wrong");
	AST_RD_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(accept && avsRead && avsAddress[1:0] != 2'h0) |=> avsReaddata == 32'h00000000)
		else $error("unmapped read not zero");
	AST_RUN_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wrHit && avsAddress == `QEC_OFS_RUN) |=> runReg == $past(avsWritedata[2:0]))
		else $error("run bits not written");
	// two edges from pin to decoder
	AST_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		($past(rst_n) && $past(rst_n, 2)) |-> sync2Reg == $past(pinRaw, 2))
		else $error("synchroniser latency wrong");
	AST_IDX_ARM: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!modeReg[`QEC_MODE_IDXEN_BIT] |=> !idxArmedReg)
		else $error("index armed while disabled");
	AST_IDX_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!idxActive |=> !idxPendReg)
		else $error("index pending while inactive");
	AST_IDX_PEND: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(idxActive && idxEdge) |=> idxPendReg)
		else $error("index edge not held");

	// ==========================================================
	// per-channel decode and counter
	genvar gi;
	generate
		for (gi = 0; gi < `QEC_NUM_CH; gi++) begin : gCh
			logic aNow;
			logic aOld;
			logic bNow;
			logic bOld;
			logic useX4;
			logic freeRun;
			logic evNorm;
			logic evX4;
			qec_dir_e dir;
			logic wrapUp;
			logic wrapDown;
			logic doClear;
			logic startedReg;

			assign aNow = sync2Reg[3 + gi];
			assign aOld = prevReg[3 + gi];
			assign bNow = sync2Reg[gi];
			assign bOld = prevReg[gi];
			assign useX4 = (gi == 2) | ((gi == 1) & modeReg[`QEC_MODE_X4SEL_BIT]);
			assign freeRun = modeReg[`QEC_MODE_FREE_LSB + gi];
			assign evNorm = aNow & (bNow ^ bOld);
			assign evX4 = (aNow ^ aOld) ^ (bNow ^ bOld);
			assign dir = (useX4 ? (aNow ^ bOld) : bNow) ? QEC_UP : QEC_DOWN;
			assign countEv[gi] = runReg[gi] & (useX4 ? evX4 : evNorm);
			assign wrapUp = (dir == QEC_UP) & (cntReg[gi] == `QEC_CNT_MAX);
			assign wrapDown = (dir == QEC_DOWN) & (cntReg[gi] == `QEC_CNT_MIN);
			assign doClear = (gi == 1) & idxPendReg & idxActive;

			// first count edge after start
			always_ff @(posedge clk_sys) begin
				if (!rst_n || !runReg[gi]) begin
					startedReg <= 1'b0;
				end else if (countEv[gi]) begin
					startedReg <= 1'b1;
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					reloadReg[gi] <= `QEC_CNT_RST;
				end else if (cntWrSel[gi]) begin
					reloadReg[gi] <= avsWritedata[15:0];
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					cntReg[gi] <= `QEC_CNT_RST;
				end else if (cntWrSel[gi] && !startedReg) begin
					cntReg[gi] <= avsWritedata[15:0];
				end else if (countEv[gi]) begin
					if (doClear) begin
						cntReg[gi] <= `QEC_CNT_MIN;
					end else if (wrapUp || wrapDown) begin
						cntReg[gi] <= freeRun ? (cntReg[gi] + (wrapUp ? 16'h0001 : 16'hFFFF))
							: reloadReg[gi];
					end else begin
						cntReg[gi] <= cntReg[gi] + ((dir == QEC_UP) ? 16'h0001 : 16'hFFFF);
					end
				end
			end

			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					irqReq[gi] <= 1'b0;
				end else begin
					irqReq[gi] <= countEv[gi] & ~doClear & (wrapUp | wrapDown);
				end
			end

			// ==========================================================
			// checks
			AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(!runReg[gi] && !cntWrSel[gi]) |=> $stable(cntReg[gi]))
				else $error("count moved while stopped");
			AST_IRQ_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !doClear && (wrapUp || wrapDown) && !(cntWrSel[gi] && !startedReg))
				|=> irqReq[gi])
				else $error("wrap without interrupt request");
			AST_RELOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !doClear && !freeRun && (wrapUp || wrapDown)
				&& !(cntWrSel[gi] && !startedReg)) |=> cntReg[gi] == $past(reloadReg[gi]))
				else $error("reload value not loaded");
			AST_FREE_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !doClear && freeRun && wrapUp && !(cntWrSel[gi] && !startedReg))
				|=> cntReg[gi] == `QEC_CNT_MIN)
				else $error("free-run overflow not at zero");
			AST_STEP_UP: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !doClear && dir == QEC_UP && !wrapUp && !cntWrSel[gi])
				|=> cntReg[gi] == $past(cntReg[gi]) + 16'h0001)
				else $error("up step missing");
			AST_WR_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(cntWrSel[gi] && !startedReg) |=> (cntReg[gi] == $past(avsWritedata[15:0])
				&& reloadReg[gi] == $past(avsWritedata[15:0])))
				else $error("idle write did not load both");
			AST_WR_RUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(cntWrSel[gi] && startedReg && !countEv[gi]) |=> ($stable(cntReg[gi])
				&& reloadReg[gi] == $past(avsWritedata[15:0])))
				else $error("running write touched counter");
			AST_NORM_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !useX4) |-> (aNow && bNow != bOld))
				else $error("normal count without a high");
			AST_IDX_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(doClear && countEv[gi] && !cntWrSel[gi]) |=> cntReg[gi] == `QEC_CNT_MIN)
				else $error("index clear missed");
			AST_NORM_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(!useX4 && !aNow && !cntWrSel[gi]) |=> $stable(cntReg[gi]))
				else $error("normal count moved with a low");
			AST_NORM_DOWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !useX4 && !bNow && !wrapDown && !cntWrSel[gi])
				|=> cntReg[gi] == $past(cntReg[gi]) - 16'h0001)
				else $error("normal falling edge did not count down");
			AST_STEP_DOWN: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !doClear && dir == QEC_DOWN && !wrapDown && !cntWrSel[gi])
				|=> cntReg[gi] == $past(cntReg[gi]) - 16'h0001)
				else $error("down step missing");
			AST_X4_DOUBLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(useX4 && aNow != aOld && bNow != bOld && !cntWrSel[gi]) |=> $stable(cntReg[gi]))
				else $error("double phase change counted");
			AST_FREE_UNDER: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(countEv[gi] && !doClear && freeRun && wrapDown && !(cntWrSel[gi] && !startedReg))
				|=> cntReg[gi] == `QEC_CNT_MAX)
				else $error("free-run underflow not at maximum");
			AST_IRQ_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
				!(countEv[gi] && (wrapUp || wrapDown)) |=> !irqReq[gi])
				else $error("interrupt request without wrap");
			AST_CLEAR_NOIRQ: assert property (@(posedge clk_sys) disable iff (!rst_n)
				(doClear && countEv[gi]) |=> !irqReq[gi])
				else $error("index clear raised interrupt request");
			AST_STARTED: assert property (@(posedge clk_sys) disable iff (!rst_n)
				countEv[gi] |=> startedReg)
				else $error("first count edge not recorded");
			AST_RUN_STOP: assert property (@(posedge clk_sys) disable iff (!rst_n)
				!runReg[gi] |=> !startedReg)
				else $error("stopped channel still marked started");
			AST_RELOAD_WR: assert property (@(posedge clk_sys) disable iff (!rst_n)
				cntWrSel[gi] |=> reloadReg[gi] == $past(avsWritedata[15:0]))
				else $error("reload not written");
		end
	endgenerate

endmodule // qec_top

// file: test/qec_encoder_model.sv
// two-phase encoder model driving the phase and index pins
`timescale 1ns/1ns
module qec_encoder_model (
	input wire logic clk_sys, // system clock
	output logic [2:0] phaseA, // phase a pins
	output logic [2:0] phaseB, // phase b pins
	output logic indexPulse // index pin
);
	logic [1:0] posReg [3];
	initial begin
		phaseA = 3'h0;
		phaseB = 3'h0;
		indexPulse = 1'b0;
		posReg = '{default: 2'h0};
	end
	task automatic hold();
		repeat (4) @(posedge clk_sys);
	endtask
	// one gray step, a leads b when forward
	task automatic step(input int ch, input bit fwd);
		@(posedge clk_sys);
		posReg[ch] = fwd ? posReg[ch] + 2'h1 : posReg[ch] - 2'h1;
		phaseA[ch] <= posReg[ch][1] ^ posReg[ch][0];
		phaseB[ch] <= posReg[ch][1];
		hold();
	endtask
	task automatic pulseIndex();
		@(posedge clk_sys);
		indexPulse <= 1'b1;
		hold();
		indexPulse <= 1'b0;
		hold();
	endtask
endmodule // qec_encoder_model

// file: test/tb_top.sv
// self-checking bench for the quadrature event counter
`timescale 1ns/1ns
`include "qec_cfg.svh"
module tb_top;
	import qec_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	qec_addr_t avsAddress = 5'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	qec_word_t avsWritedata = 32'h00000000;
	qec_word_t avsReaddata;
	logic avsWaitrequest;
	logic [2:0] phaseA;
	logic [2:0] phaseB;
	logic indexPulse;
	logic [2:0] irqReq;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int irqCount [3] = '{0, 0, 0};

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	qec_top DUT (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.avsAddress(avsAddress),
		.avsRead(avsRead),
		.avsWrite(avsWrite),
		.avsWritedata(avsWritedata),
		.avsReaddata(avsReaddata),
		.avsWaitrequest(avsWaitrequest),
		.phaseAIn(phaseA),
		.phaseBIn(phaseB),
		.indexPulseIn(indexPulse),
		.irqReq(irqReq)
	);

	qec_encoder_model ENC (
		.clk_sys(clk_sys),
		.phaseA(phaseA),
		.phaseB(phaseB),
		.indexPulse(indexPulse)
	);

	// ==========================================================
	// irq pulse counting and timeout
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		for (int i = 0; i < 3; i++) begin
			if (irqReq[i] === 1'b1) begin
				irqCount[i] <= irqCount[i] + 1;
			end
		end
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	// ==========================================================
	// helpers
	task automatic summarize();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input qec_word_t seen, input qec_word_t exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// one avalon access, held until waitrequest low
	task automatic busAccess(input qec_addr_t addr, input bit wr, input qec_word_t data,
		output qec_word_t rd);
		avsAddress <= addr;
		avsWritedata <= data;
		avsWrite <= wr;
		avsRead <= !wr;
		@(posedge clk_sys);
		while (avsWaitrequest !== 1'b0) begin
			@(posedge clk_sys);
		end
		rd = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input qec_addr_t addr, input qec_word_t data);
		qec_word_t unused;
		busAccess(addr, 1'b1, data, unused);
	endtask

	task automatic expectRead(input qec_addr_t addr, input qec_word_t exp);
		qec_word_t rd;
		busAccess(addr, 1'b0, 32'h00000000, rd);
		check(rd, exp);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		expectRead(`QEC_OFS_CNT2, 32'h00000000);
		expectRead(5'h0C, 32'h00000000);
		// ch3 free x4, index on rising; ch2 and ch4 reload
		wr(`QEC_OFS_MODE, 32'h0000003A);
		// channel 2 normal processing
		wr(`QEC_OFS_CNT2, 32'h00000005);
		expectRead(`QEC_OFS_CNT2, 32'h00000005);
		wr(`QEC_OFS_RUN, 32'h00000001);
		wr(`QEC_OFS_CNT2, 32'h00000007);
		expectRead(`QEC_OFS_CNT2, 32'h00000007);
		repeat (4) ENC.step(0, 1'b1);
		expectRead(`QEC_OFS_CNT2, 32'h00000008);
		repeat (4) ENC.step(0, 1'b0);
		expectRead(`QEC_OFS_CNT2, 32'h00000007);
		wr(`QEC_OFS_CNT2, 32'h00001234);
		expectRead(`QEC_OFS_CNT2, 32'h00000007);
		wr(`QEC_OFS_RUN, 32'h00000000);
		repeat (4) ENC.step(0, 1'b1);
		expectRead(`QEC_OFS_CNT2, 32'h00000007);
		// channel 4 x4 with reload wrap
		wr(`QEC_OFS_CNT4, 32'h0000FFFE);
		wr(`QEC_OFS_RUN, 32'h00000004);
		ENC.step(2, 1'b1);
		expectRead(`QEC_OFS_CNT4, 32'h0000FFFF);
		ENC.step(2, 1'b1);
		expectRead(`QEC_OFS_CNT4, 32'h0000FFFE);
		check(qec_word_t'(irqCount[2]), 32'h00000001);
		wr(`QEC_OFS_CNT4, 32'h0000FFFD);
		expectRead(`QEC_OFS_CNT4, 32'h0000FFFE);
		repeat (2) ENC.step(2, 1'b1);
		expectRead(`QEC_OFS_CNT4, 32'h0000FFFD);
		ENC.step(2, 1'b0);
		expectRead(`QEC_OFS_CNT4, 32'h0000FFFC);
		// channel 3 index clear and free-run underflow
		wr(`QEC_OFS_CNT3, 32'h00000000);
		wr(`QEC_OFS_RUN, 32'h00000002);
		repeat (3) ENC.step(1, 1'b1);
		expectRead(`QEC_OFS_CNT3, 32'h00000003);
		ENC.pulseIndex();
		expectRead(`QEC_OFS_CNT3, 32'h00000003);
		ENC.step(1, 1'b1);
		expectRead(`QEC_OFS_CNT3, 32'h00000000);
		ENC.step(1, 1'b0);
		expectRead(`QEC_OFS_CNT3, 32'h0000FFFF);
		check(qec_word_t'(irqCount[1]), 32'h00000001);
		check(qec_word_t'(irqCount[0]), 32'h00000000);
		expectRead(`QEC_OFS_RUN, 32'h00000002);
		expectRead(`QEC_OFS_MODE, 32'h0000003A);
		// ch3 falling index, zero written while running
		wr(`QEC_OFS_MODE, 32'h0000001A);
		wr(`QEC_OFS_CNT3, 32'h00000000);
		expectRead(`QEC_OFS_CNT3, 32'h0000FFFF);
		ENC.pulseIndex();
		ENC.step(1, 1'b0);
		expectRead(`QEC_OFS_CNT3, 32'h00000000);
		// index disabled: plain free-run underflow
		wr(`QEC_OFS_MODE, 32'h0000000A);
		ENC.pulseIndex();
		ENC.step(1, 1'b0);
		expectRead(`QEC_OFS_CNT3, 32'h0000FFFF);
		// ch3 normal processing, free-run overflow
		wr(`QEC_OFS_MODE, 32'h00000002);
		repeat (4) ENC.step(1, 1'b1);
		expectRead(`QEC_OFS_CNT3, 32'h00000000);
		check(qec_word_t'(irqCount[1]), 32'h00000003);
		// ch2 reload underflow, period n+1
		wr(`QEC_OFS_CNT2, 32'h00000001);
		wr(`QEC_OFS_RUN, 32'h00000001);
		repeat (8) ENC.step(0, 1'b0);
		expectRead(`QEC_OFS_CNT2, 32'h00000001);
		check(qec_word_t'(irqCount[0]), 32'h00000001);
		summarize();
	end
endmodule // tb_top
